// >>> serial_defs.vh
/*
 * Constants for the dual-port asynchronous serial block: register offsets,
 * field positions, reset values, format codes and timing counts.
 * Assumes a 25 MHz system clock and 16x oversampling of each bit.
 */
`ifndef SERIAL_DEFS_VH
`define SERIAL_DEFS_VH

// ************************************************************
// Register offsets (word index on the plain register port)
// ************************************************************
`define REG_CONFIG      4'h0
`define REG_STATUS      4'h1
`define REG_TX_DATA     4'h2
`define REG_RX_DATA     4'h3
`define REG_DIAG_TX     4'h4
`define REG_DIAG_RX     4'h5

// ************************************************************
// Configuration field positions
// ************************************************************
`define CFG_SPEED_LO    0
`define CFG_SPEED_HI    2
`define CFG_EIGHT_BIT   3
`define CFG_PAR_LO      4
`define CFG_PAR_HI      5
`define CFG_TWO_STOP    6
`define CFG_DATA_ON_SEC 7
`define CFG_SEC_LO      8
`define CFG_SEC_HI      9
`define CFG_RESET       10'h00b

// ************************************************************
// Encodings
// ************************************************************
`define PAR_NONE        2'h0
`define PAR_EVEN        2'h1
`define PAR_ODD         2'h2
`define IF_RS232        2'h0
`define IF_RS422        2'h1
`define IF_RS485        2'h2

// ************************************************************
// Timing: clock rate, oversampling, speeds in bps
// ************************************************************
`define CLOCK_HZ        25000000
`define OVERSAMPLE      16
`define BPS_1200        1200
`define BPS_2400        2400
`define BPS_4800        4800
`define BPS_9600        9600
`define BPS_19200       19200
`define BPS_38400       38400
`define TICK_DIV(b)     ((`CLOCK_HZ / ((b) * `OVERSAMPLE)) - 1)

`endif

// >>> dual_port_async_serial.v
/*
 * Dual-port asynchronous serial interface of a radio modem (DCE side).
 * One port carries user data, the other a fixed-format diagnostics link.
 * Assumes one 25 MHz clock, a synchronous active-low reset, and pins that
 * arrive asynchronously; RS-422/485 transceivers sit outside the chip.
 */
// Summary of operation
// - Two ports, one data, one diagnostics, selectable
// - Primary port is always RS-232
// - Secondary port RS-232, RS-422 or RS-485
// - Handshake lines follow the data port
// - Grounded mode pin forces setup on primary
// - Data port speeds, length, parity, stops selectable
// - Diagnostics fixed 9600, 8 bits, even, one stop
// - No 300/600 bps, no 9-bit characters
// - Start, data, optional parity, stop bits
// - Start bit low, stop bits high
// - Line A above B reads as one
// - RS-485 is half duplex on one pair
// - Settings change only in setup or display
`timescale 1ns/1ps
`include "serial_defs.vh"

// ************************************************************
// One character engine: transmitter plus receiver
// ************************************************************
module serial_engine
(
  // Clock and control
  input  wire       clock,
  input  wire       rst_b,
  input  wire       enable,
  // Format
  input  wire [2:0] speed,
  input  wire       eight_bit,
  input  wire [1:0] parity,
  input  wire       two_stop,
  // Transmit side
  input  wire       tx_start,
  input  wire [7:0] tx_byte,
  output reg        tx_busy,
  output reg        tx_line,
  // Receive side
  input  wire       rx_line,
  output reg        rx_done,
  output reg  [7:0] rx_byte,
  output reg        rx_error
);
  localparam IDLE = 2'h0;
  localparam START = 2'h1;
  localparam SHIFT = 2'h2;
  localparam STOP = 2'h3;
  // Divider limits, kept as integers and cut to the divider width where used
  localparam integer DIV_1200  = `TICK_DIV(`BPS_1200);
  localparam integer DIV_2400  = `TICK_DIV(`BPS_2400);
  localparam integer DIV_4800  = `TICK_DIV(`BPS_4800);
  localparam integer DIV_9600  = `TICK_DIV(`BPS_9600);
  localparam integer DIV_19200 = `TICK_DIV(`BPS_19200);
  localparam integer DIV_38400 = `TICK_DIV(`BPS_38400);

  reg  [10:0] div_cnt;    // Oversample divider
  reg  [10:0] div_max;    // Divider limit for the chosen speed
  wire        tick;       // One oversample tick
  reg  [3:0]  tx_phase;   // Oversample phase within a transmit bit
  reg  [3:0]  tx_left;    // Bits still to send
  reg  [11:0] tx_frame;   // Shift register, bit 0 on the line next
  reg  [1:0]  rx_state;   // Receiver state
  reg  [3:0]  rx_phase;   // Oversample phase within a receive bit
  reg  [3:0]  rx_left;    // Data plus parity bits still to take
  reg  [8:0]  rx_shift;   // Collected data and parity
  wire [3:0]  nbits;      // Data bit count
  wire        par_bit;    // Parity of the outgoing byte

  // Speed table; 300 and 600 bps are deliberately absent
  always @*
  begin
    case (speed)
      3'h0:    div_max = DIV_1200[10:0];
      3'h1:    div_max = DIV_2400[10:0];
      3'h2:    div_max = DIV_4800[10:0];
      3'h3:    div_max = DIV_9600[10:0];
      3'h4:    div_max = DIV_19200[10:0];
      default: div_max = DIV_38400[10:0];
    endcase
  end

  // At or above the limit, so a speed change mid-count cannot stall for a full wrap
  assign tick = (div_cnt >= div_max);
  assign nbits = eight_bit ? 4'h8 : 4'h7;  // Never nine bits
  // Parity over data bits only; odd inverts
  assign par_bit = (eight_bit ? ^tx_byte : ^tx_byte[6:0]) ^ (parity == `PAR_ODD);

  // Oversample divider
  always @(posedge clock)
  begin
    if (!rst_b)
      div_cnt <= 11'h000;
    else if (enable)
      div_cnt <= tick ? 11'h000 : div_cnt + 11'h001;
  end

  // Transmitter: frame built as start, data LSB first, parity, stops
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      tx_busy  <= 1'b0;
      tx_line  <= 1'b1;
      tx_phase <= 4'h0;
      tx_left  <= 4'h0;
      tx_frame <= 12'hfff;
    end
    else if (enable)
    begin
      if (!tx_busy && tx_start)
      begin
        // Stop bits high fill the top; shift puts LSB first
        tx_frame <= eight_bit ? {2'h3, par_bit, tx_byte, 1'b0} :
                                {3'h7, par_bit, tx_byte[6:0], 1'b0};
        if (parity == `PAR_NONE)
          tx_frame <= eight_bit ? {3'h7, tx_byte, 1'b0} : {4'hf, tx_byte[6:0], 1'b0};
        tx_left  <= 4'h2 + nbits + {3'h0, parity != `PAR_NONE} + {3'h0, two_stop};
        tx_busy  <= 1'b1;
        tx_phase <= 4'h0;
      end
      else if (tx_busy && tick)
      begin
        tx_line <= tx_frame[0];  // Start goes out low, stops high
        tx_phase <= tx_phase + 4'h1;
        if (tx_phase == 4'hf)
        begin
          tx_frame <= {1'b1, tx_frame[11:1]};
          tx_left  <= tx_left - 4'h1;
          if (tx_left == 4'h1)
            tx_busy <= 1'b0;
        end
      end
      else if (!tx_busy)
        tx_line <= 1'b1;  // Idle line rests at mark
    end
  end

  // Receiver: validate start at mid-bit, then sample each bit centre
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      rx_state <= IDLE;
      rx_phase <= 4'h0;
      rx_left  <= 4'h0;
      rx_shift <= 9'h000;
      rx_done  <= 1'b0;
      rx_byte  <= 8'h00;
      rx_error <= 1'b0;
    end
    else if (enable)
    begin
      rx_done <= 1'b0;
      if (tick)
      begin
        case (rx_state)
          IDLE:
          begin
            rx_phase <= 4'h0;
            if (!rx_line)
              rx_state <= START;
          end
          START:
          begin
            rx_phase <= rx_phase + 4'h1;
            if (rx_phase == 4'h7)
            begin
              // A glitch shorter than half a bit is dropped
              rx_state <= rx_line ? IDLE : SHIFT;
              rx_phase <= 4'h0;
              rx_left  <= nbits + {3'h0, parity != `PAR_NONE};
            end
          end
          SHIFT:
          begin
            rx_phase <= rx_phase + 4'h1;
            if (rx_phase == 4'hf)
            begin
              rx_shift <= {rx_line, rx_shift[8:1]};  // LSB arrives first
              rx_left  <= rx_left - 4'h1;
              if (rx_left == 4'h1)
                rx_state <= STOP;
            end
          end
          STOP:
          begin
            rx_phase <= rx_phase + 4'h1;
            if (rx_phase == 4'hf)
            begin
              rx_state <= IDLE;
              rx_done  <= 1'b1;
              // Align the collected bits, then check parity and stop
              if (parity == `PAR_NONE)
              begin
                rx_byte  <= eight_bit ? rx_shift[8:1] : {1'b0, rx_shift[8:2]};
                rx_error <= !rx_line;  // Stop must be high
              end
              else
              begin
                rx_byte  <= eight_bit ? rx_shift[7:0] : {1'b0, rx_shift[7:1]};
                rx_error <= !rx_line | ((eight_bit ? ^rx_shift : ^rx_shift[8:1]) ^ (parity == `PAR_ODD));
              end
            end
          end
          default: rx_state <= IDLE;
        endcase
      end
    end
  end
endmodule // serial_engine

// ************************************************************
// Top level: role routing, register port, handshake
// ************************************************************
module dual_port_async_serial
(
  // Clock, reset, enable
  input  wire       clock,
  input  wire       rst_b,
  input  wire       clock_enable,
  // Register port
  input  wire [3:0] reg_addr,
  input  wire [9:0] reg_wdata,
  input  wire       reg_write,
  input  wire       reg_read,
  output reg  [9:0] reg_rdata,
  // Setup and display access
  input  wire       mode_pin_b,
  input  wire       display_cfg,
  // Primary port, RS-232 only
  input  wire       port1_rx,
  output reg        port1_tx,
  // Secondary port; single-ended level or sign of A minus B
  input  wire       port2_rx,
  output reg        port2_tx,
  output reg        port2_tx_oe,
  output reg  [1:0] port2_type,
  // Handshake lines, always RS-232
  input  wire       rts_in,
  input  wire       dtr_in,
  output reg        cts_out,
  output reg        cd_out,
  output reg        dsr_out,
  input  wire       carrier
);
  reg  [9:0] config_reg;  // Format, role and secondary type
  reg  [2:0] sync1;       // Primary rx synchroniser
  reg  [2:0] sync2;       // Secondary rx synchroniser
  reg  [2:0] syncm;       // Mode pin synchroniser
  reg        rx1;         // Filtered primary rx
  reg        rx2;         // Filtered secondary rx
  reg        setup;       // Filtered setup state
  reg        data_start;  // Transmit request, data engine
  reg        diag_start;  // Transmit request, diagnostics engine
  reg  [7:0] data_tx;     // Data byte to send
  reg  [7:0] diag_tx;     // Diagnostics byte to send
  reg  [7:0] data_rx;     // Last data byte received
  reg  [7:0] diag_rx;     // Last diagnostics byte received
  reg  [3:0] flags;       // Receive valid and error flags
  wire       data_on_sec; // Data role on the secondary port
  wire       rx2_heard;   // Secondary rx with our own RS-485 echo blanked
  wire       d_busy;
  wire       d_line;
  wire       d_done;
  wire [7:0] d_byte;
  wire       d_err;
  wire       g_busy;
  wire       g_line;
  wire       g_done;
  wire [7:0] g_byte;
  wire       g_err;

  // Setup forces data traffic onto the primary port
  assign data_on_sec = config_reg[`CFG_DATA_ON_SEC] & !setup;

  // Half duplex: while we drive the pair the receiver hears mark only
  assign rx2_heard = rx2 | (port2_tx_oe & (port2_type == `IF_RS485));

  // Three-stage synchronisers; change accepted when stages 2 and 3 agree
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
      syncm <= 3'h7;
      rx1   <= 1'b1;
      rx2   <= 1'b1;
      setup <= 1'b0;
    end
    else if (clock_enable)
    begin
      sync1 <= {sync1[1:0], port1_rx};
      sync2 <= {sync2[1:0], port2_rx};  // A above B arrives as one
      syncm <= {syncm[1:0], mode_pin_b};
      if (sync1[1] == sync1[2])
        rx1 <= sync1[2];
      if (sync2[1] == sync2[2])
        rx2 <= sync2[2];
      if (syncm[1] == syncm[2])
        setup <= !syncm[2];  // Grounded pin means setup
    end
  end

  // User data engine with selectable format
  serial_engine data_engine
  (
    .clock     (clock),
    .rst_b     (rst_b),
    .enable    (clock_enable),
    .speed     (config_reg[`CFG_SPEED_HI:`CFG_SPEED_LO]),
    .eight_bit (config_reg[`CFG_EIGHT_BIT]),
    .parity    (config_reg[`CFG_PAR_HI:`CFG_PAR_LO]),
    .two_stop  (config_reg[`CFG_TWO_STOP]),
    .tx_start  (data_start),
    .tx_byte   (data_tx),
    .tx_busy   (d_busy),
    .tx_line   (d_line),
    .rx_line   (data_on_sec ? rx2_heard : rx1),
    .rx_done   (d_done),
    .rx_byte   (d_byte),
    .rx_error  (d_err)
  );

  // Diagnostics engine, fixed 9600 8E1
  serial_engine diag_engine
  (
    .clock     (clock),
    .rst_b     (rst_b),
    .enable    (clock_enable),
    .speed     (3'h3),
    .eight_bit (1'b1),
    .parity    (`PAR_EVEN),
    .two_stop  (1'b0),
    .tx_start  (diag_start),
    .tx_byte   (diag_tx),
    .tx_busy   (g_busy),
    .tx_line   (g_line),
    .rx_line   (data_on_sec ? rx1 : rx2_heard),
    .rx_done   (g_done),
    .rx_byte   (g_byte),
    .rx_error  (g_err)
  );

  // Register writes; format changes only in setup or via display
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      config_reg <= `CFG_RESET;
      data_start <= 1'b0;
      diag_start <= 1'b0;
      data_tx    <= 8'h00;
      diag_tx    <= 8'h00;
    end
    else if (clock_enable)
    begin
      data_start <= 1'b0;
      diag_start <= 1'b0;
      if (reg_write && reg_addr == `REG_CONFIG && (setup || display_cfg))
        config_reg <= reg_wdata;
      // A request still in flight refuses the write too; busy shows a cycle later
      if (reg_write && reg_addr == `REG_TX_DATA && !d_busy && !data_start)
      begin
        data_tx    <= reg_wdata[7:0];
        data_start <= 1'b1;
      end
      if (reg_write && reg_addr == `REG_DIAG_TX && !g_busy && !diag_start)
      begin
        diag_tx    <= reg_wdata[7:0];
        diag_start <= 1'b1;
      end
    end
  end

  // Receive data and sticky flags; a new byte wins over a read-clear
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      data_rx <= 8'h00;
      diag_rx <= 8'h00;
      flags   <= 4'h0;
    end
    else if (clock_enable)
    begin
      if (reg_read && reg_addr == `REG_RX_DATA)
        flags[1:0] <= 2'h0;
      if (reg_read && reg_addr == `REG_DIAG_RX)
        flags[3:2] <= 2'h0;
      if (d_done)
      begin
        data_rx  <= d_byte;
        flags[0] <= 1'b1;
        flags[1] <= d_err;
      end
      if (g_done)
      begin
        diag_rx  <= g_byte;
        flags[2] <= 1'b1;
        flags[3] <= g_err;
      end
    end
  end

  // Read data one cycle after the read strobe; unmapped reads zero
  always @(posedge clock)
  begin
    if (!rst_b)
      reg_rdata <= 10'h000;
    else if (clock_enable)
    begin
      reg_rdata <= 10'h000;
      if (reg_read)
      begin
        case (reg_addr)
          `REG_CONFIG:  reg_rdata <= config_reg;
          `REG_STATUS:  reg_rdata <= {setup, data_on_sec, g_busy, d_busy, 2'h0, flags};
          `REG_RX_DATA: reg_rdata <= {2'h0, data_rx};
          `REG_DIAG_RX: reg_rdata <= {2'h0, diag_rx};
          default:      reg_rdata <= 10'h000;
        endcase
      end
    end
  end

  // Pin routing; the secondary type is ignored for the primary port
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      port1_tx    <= 1'b1;
      port2_tx    <= 1'b1;
      port2_tx_oe <= 1'b0;
      port2_type  <= `IF_RS232;
      cts_out     <= 1'b0;
      cd_out      <= 1'b0;
      dsr_out     <= 1'b0;
    end
    else if (clock_enable)
    begin
      port1_tx   <= data_on_sec ? g_line : d_line;
      port2_tx   <= data_on_sec ? d_line : g_line;
      port2_type <= config_reg[`CFG_SEC_HI:`CFG_SEC_LO];
      // RS-485 drives the pair only while sending
      if (config_reg[`CFG_SEC_HI:`CFG_SEC_LO] == `IF_RS485)
        port2_tx_oe <= data_on_sec ? d_busy : g_busy;
      else
        port2_tx_oe <= 1'b1;
      // Handshake belongs to whichever port holds data
      cts_out <= !d_busy & dtr_in & rts_in;
      cd_out  <= carrier;
      dsr_out <= 1'b1;
    end
  end
endmodule // dual_port_async_serial

// >>> serial_port_checker.sv
/*
 * Port-level assertions for the dual-port asynchronous serial block.
 * Assumes one clock with a synchronous active-low reset; bound below.
 */
`timescale 1ns/1ps
`include "serial_defs.vh"

// ************************************************************
// Checker
// ************************************************************
module serial_port_checker
(
  // Clock and reset
  input wire       clock,
  input wire       rst_b,
  // Register port
  input wire [3:0] reg_addr,
  input wire [9:0] reg_wdata,
  input wire       reg_write,
  input wire       reg_read,
  input wire [9:0] reg_rdata,
  // Setup access
  input wire       mode_pin_b,
  input wire       display_cfg,
  // Serial pins
  input wire       port1_tx,
  input wire       port2_tx,
  input wire       port2_tx_oe,
  input wire [1:0] port2_type,
  // Handshake
  input wire       rts_in,
  input wire       dtr_in,
  input wire       cts_out,
  input wire       cd_out,
  input wire       dsr_out,
  input wire       carrier
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Status read with the mode pin settled past the synchroniser
  sequence setup_read;
    (!mode_pin_b) [*6] ##0 (reg_read && reg_addr == `REG_STATUS);
  endsequence
  sequence run_read;
    mode_pin_b [*6] ##0 (reg_read && reg_addr == `REG_STATUS);
  endsequence
  // Configuration write through the display path
  sequence display_write;
    reg_write && display_cfg && reg_addr == `REG_CONFIG;
  endsequence

  a_rdata_quiet: assert property (!reg_read |=> reg_rdata == 10'h000)
    else $error("read data not zero outside its slot");
  a_unmapped_zero: assert property (reg_read && reg_addr > 4'h5 |=> reg_rdata == 10'h000)
    else $error("unmapped read not zero");
  a_setup_primary: assert property (setup_read |=> reg_rdata[9] && !reg_rdata[8])
    else $error("setup state not on primary port");
  a_run_flag: assert property (run_read |=> !reg_rdata[9])
    else $error("setup flag set with mode pin high");
  a_type_follows: assert property (display_write |-> ##2 port2_type == $past(reg_wdata[9:8], 2))
    else $error("secondary type not taken");
  a_oe_full: assert property ($past(rst_b) && port2_type != `IF_RS485 && $past(port2_type) != `IF_RS485
                              |-> port2_tx_oe)
    else $error("driver off outside half duplex");
  a_release_stop: assert property (port2_type == `IF_RS485 && $fell(port2_tx_oe) |-> $past(port2_tx))
    else $error("pair released before stop level");
  a_start1_width: assert property ($fell(port1_tx) |-> (!port1_tx) [*8])
    else $error("primary start bit too short");
  a_start2_width: assert property ($fell(port2_tx) && port2_tx_oe |-> (!port2_tx) [*8])
    else $error("secondary start bit too short");
  a_cts_blocked: assert property (!(rts_in && dtr_in) |=> !cts_out)
    else $error("clear to send without request");
  a_cd_tracks: assert property ($rose(carrier) |-> ##[1:2] cd_out)
    else $error("carrier detect late");
  a_dsr_up: assert property ($past(rst_b) |-> dsr_out)
    else $error("set ready low after reset");
endmodule // serial_port_checker

bind dual_port_async_serial serial_port_checker chk_i (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_write,
  .reg_read, .reg_rdata, .mode_pin_b, .display_cfg, .port1_tx, .port2_tx, .port2_tx_oe, .port2_type,
  .rts_in, .dtr_in, .cts_out, .cd_out, .dsr_out, .carrier);

// >>> terminal_model.sv
/*
 * Behavioural terminal on one serial line: sends and decodes characters.
 * Assumes the bench sets the format before each transfer.
 */
`timescale 1ns/1ps

// ************************************************************
// Terminal model
// ************************************************************
module terminal_model
(
  // Line from the device, line toward it
  input wire line_in,
  output reg line_out,
  output reg line_oe
);
  integer bit_ns = 25600; // Bit period
  integer nbits  = 8;     // Data bits
  integer par    = 0;     // 0 none, 1 even, 2 odd
  integer stops  = 1;     // Stop bits
  integer i;

  // Idle at mark level, not driving
  initial
  begin
    line_out = 1'b1;
    line_oe = 1'b0;
  end

  // Parity over the data bits only
  function pbit(input [7:0] d);
    pbit = (^(d & ((1 << nbits) - 1))) ^ (par == 2);
  endfunction

  // Same format as the device port
  task fmt(input integer b, input integer n, input integer p, input integer s);
    bit_ns = b;
    nbits = n;
    par = p;
    stops = s;
  endtask

  // One character; bad flips the parity bit
  task send(input [7:0] d, input bad);
    #7; // Keep line edges off the device's clock edge
    line_oe = 1'b1;
    line_out = 1'b0;
    #(bit_ns);
    for (i = 0; i < nbits; i = i + 1)
    begin
      line_out = d[i];
      #(bit_ns);
    end
    if (par != 0)
    begin
      line_out = pbit(d) ^ bad;
      #(bit_ns);
    end
    line_out = 1'b1;
    #(bit_ns * stops);
    line_oe = 1'b0;
  endtask

  // Decode one character at mid-bit; ok clears on any framing fault
  task recv(output [7:0] d, output ok);
    @(negedge line_in);
    #(bit_ns / 2);
    ok = (line_in === 1'b0);
    d = 8'h00;
    for (i = 0; i < nbits; i = i + 1)
    begin
      #(bit_ns);
      d[i] = line_in;
    end
    if (par != 0)
    begin
      #(bit_ns);
      ok = ok & (line_in === pbit(d));
    end
    for (i = 0; i < stops; i = i + 1)
    begin
      #(bit_ns);
      ok = ok & (line_in === 1'b1);
    end
  endtask
endmodule // terminal_model

// >>> tb_dual_port_async_serial.sv
/*
 * Self-checking bench for the dual-port serial block with two terminals.
 * Assumes a 25 MHz clock and the constants of serial_defs.vh.
 */
`timescale 1ns/1ps
`include "serial_defs.vh"

module tb_dual_port_async_serial;
  // ************************************************************
  // Signals
  // ************************************************************
  reg        clock;
  reg        rst_b;
  reg        clock_enable;
  reg  [3:0] reg_addr;
  reg  [9:0] reg_wdata;
  reg        reg_write;
  reg        reg_read;
  wire [9:0] reg_rdata;
  reg        mode_pin_b;
  reg        display_cfg;
  reg        rts_in;
  reg        dtr_in;
  reg        carrier;
  wire       port1_rx;
  wire       port1_tx;
  wire       port2_tx;
  wire       port2_tx_oe;
  wire [1:0] port2_type;
  wire       cts_out;
  wire       cd_out;
  wire       dsr_out;
  wire       m2_out;
  wire       m2_oe;
  wire       p2_wire;
  integer    n_fail = 0;
  integer    samples_checked = 0;
  reg  [7:0] b1;
  reg  [7:0] b2;
  reg        o1;
  reg        o2;
  localparam integer fast_ns = 16 * (`TICK_DIV(`BPS_38400) + 1) * 40; // Bit time at 38400
  localparam integer slow_ns = 16 * (`TICK_DIV(`BPS_9600) + 1) * 40;  // Bit time at 9600

  // Shared pair: bias network holds it at mark when nobody drives
  assign p2_wire = port2_tx_oe ? port2_tx : (m2_oe ? m2_out : 1'b1);

  dual_port_async_serial uut (.clock(clock), .rst_b(rst_b), .clock_enable(clock_enable),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .mode_pin_b(mode_pin_b), .display_cfg(display_cfg), .port1_rx(port1_rx),
    .port1_tx(port1_tx), .port2_rx(p2_wire), .port2_tx(port2_tx), .port2_tx_oe(port2_tx_oe),
    .port2_type(port2_type), .rts_in(rts_in), .dtr_in(dtr_in), .cts_out(cts_out), .cd_out(cd_out),
    .dsr_out(dsr_out), .carrier(carrier));
  terminal_model m1 (.line_in(port1_tx), .line_out(port1_rx), .line_oe());
  terminal_model m2 (.line_in(p2_wire), .line_out(m2_out), .line_oe(m2_oe));

  // Clock at 25 MHz
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task chk(input [9:0] g, input [9:0] e);
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wr(input [3:0] a, input [9:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // Read, mask and compare; data stands only in the next cycle
  task rc(input [3:0] a, input [9:0] m, input [9:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata & m, e);
  endtask
  task test_done;
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog: the run needs about 3.2 ms
  initial
  begin
    #3800000;
    n_fail = n_fail + 1;
    test_done;
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial
  begin
    rst_b = 1'b0;
    clock_enable = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 10'h000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    mode_pin_b = 1'b1;
    display_cfg = 1'b0;
    rts_in = 1'b1;
    dtr_in = 1'b1;
    carrier = 1'b0;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    // Reset values, unmapped place, locked configuration
    rc(`REG_CONFIG, 10'h3ff, `CFG_RESET);
    rc(4'hf, 10'h3ff, 10'h000);
    chk({9'h000, port1_tx}, 10'h001);
    wr(`REG_CONFIG, 10'h2dd);
    rc(`REG_CONFIG, 10'h3ff, `CFG_RESET);
    // Display path: 38400 8E2, data on secondary, RS-485
    @(posedge clock);
    display_cfg <= 1'b1;
    wr(`REG_CONFIG, 10'h2dd);
    @(posedge clock);
    display_cfg <= 1'b0;
    rc(`REG_CONFIG, 10'h3ff, 10'h2dd);
    rc(`REG_STATUS, 10'h300, 10'h100);
    chk({8'h00, port2_type}, {8'h00, `IF_RS485});
    $display("test config done");
    // Both ports transmit at once, each in its own format
    m2.fmt(fast_ns, 8, 1, 2);
    m1.fmt(slow_ns, 8, 1, 1);
    fork
      begin
        wr(`REG_TX_DATA, 10'h0cc);
        wr(`REG_DIAG_TX, 10'h035);
      end
      m2.recv(b2, o2);
      m1.recv(b1, o1);
    join
    chk({2'b00, b2}, 10'h0cc);
    chk({9'h000, o2}, 10'h001);
    chk({2'b00, b1}, 10'h035);
    chk({9'h000, o1}, 10'h001);
    rc(`REG_STATUS, 10'h00f, 10'h000);
    // Both ports receive at once
    fork
      m2.send(8'ha7, 1'b0);
      m1.send(8'h81, 1'b0);
    join
    rc(`REG_STATUS, 10'h00f, 10'h005);
    rc(`REG_RX_DATA, 10'h3ff, 10'h0a7);
    rc(`REG_DIAG_RX, 10'h3ff, 10'h081);
    rc(`REG_STATUS, 10'h00f, 10'h000);
    $display("test traffic done");
    // Handshake lines
    @(posedge clock);
    rts_in <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk({9'h000, cts_out}, 10'h000);
    @(posedge clock);
    rts_in <= 1'b1;
    carrier <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk({7'h00, cts_out, cd_out, dsr_out}, 10'h007);
    $display("test handshake done");
    // Setup state overrides the role choice: 38400 7O1 on primary
    @(posedge clock);
    mode_pin_b <= 1'b0;
    repeat (6) @(posedge clock);
    rc(`REG_STATUS, 10'h300, 10'h200);
    wr(`REG_CONFIG, 10'h2a5);
    rc(`REG_CONFIG, 10'h3ff, 10'h2a5);
    m1.fmt(fast_ns, 7, 2, 1);
    fork
      wr(`REG_TX_DATA, 10'h0da);
      m1.recv(b1, o1);
    join
    chk({2'b00, b1}, 10'h05a);
    chk({9'h000, o1}, 10'h001);
    m1.send(8'h3c, 1'b0);
    rc(`REG_RX_DATA, 10'h3ff, 10'h03c);
    m1.send(8'h3c, 1'b1);
    rc(`REG_STATUS, 10'h002, 10'h002);
    // 38400 7N2: no parity bit, top data bit dropped
    wr(`REG_CONFIG, 10'h245);
    m1.fmt(fast_ns, 7, 0, 2);
    m1.send(8'hcb, 1'b0);
    rc(`REG_RX_DATA, 10'h3ff, 10'h04b);
    $display("test setup done");
    test_done;
  end
endmodule // tb_dual_port_async_serial
